// file: core/e3t_pkg.sv
/*
  Constants for the E3 G.832 transmit overhead controller: register indices,
  field positions, reset values and overhead byte positions.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package e3t_pkg;

  // Register indices; each occupies one 32-bit word at four times its index
  localparam logic [11:0] IDX_TX_OVERHEAD_CONTROL  = 12'h118;
  localparam logic [11:0] IDX_TX_ERROR_INSERTION   = 12'h11a;
  localparam logic [11:0] IDX_TX_MA_BYTE_FIELDS    = 12'h11c;
  localparam logic [11:0] IDX_TX_NR_GC_BYTE_VALUES = 12'h11e;
  localparam int          ADDR_SHIFT               = 2;

  localparam logic [15:0] REG_RESET      = 16'h0000;
  localparam logic [15:0] MASK_TCR       = 16'h073f;
  localparam logic [15:0] MASK_TEIR      = 16'h03ff;
  localparam logic [15:0] MASK_TMABR     = 16'h00ff;
  localparam logic [15:0] MASK_TNGBR     = 16'hffff;

  // tx_overhead_control fields
  localparam int B_GC_SOURCE_SELECT         = 10;
  localparam int B_NR_SOURCE_HI             = 9;
  localparam int B_NR_SOURCE_LO             = 8;
  localparam int B_MANUAL_REI_BIT           = 5;
  localparam int B_AUTO_REI_DEFEAT          = 4;
  localparam int B_MANUAL_RDI_BIT           = 3;
  localparam int B_AUTO_RDI_DEFEAT          = 2;
  localparam int B_FRAME_GENERATION_DISABLE = 1;
  localparam int B_FORCE_ALL_ONES_OUTPUT    = 0;

  // tx_error_insertion fields
  localparam int B_REI_ERROR_CONTINUOUS        = 9;
  localparam int B_REI_ERROR_ENABLE            = 8;
  localparam int B_PARITY_BLOCK_ERROR_MODE     = 7;
  localparam int B_PARITY_ERROR_CONTINUOUS     = 6;
  localparam int B_PARITY_ERROR_ENABLE         = 5;
  localparam int B_FRAMING_TYPE_HI             = 4;
  localparam int B_FRAMING_TYPE_LO             = 3;
  localparam int B_FRAMING_ERROR_ENABLE        = 2;
  localparam int B_SINGLE_ERROR_TRIGGER        = 1;
  localparam int B_ERROR_TRIGGER_SOURCE_SELECT = 0;

  // tx_ma_byte_fields fields
  localparam int B_PAYLOAD_TYPE_HI         = 7;
  localparam int B_PAYLOAD_TYPE_LO         = 5;
  localparam int B_TIMING_SOURCE_GEN_DIS   = 4;
  localparam int B_TIMING_SOURCE_HI        = 3;

  localparam logic [1:0] NR_ALL_ONES = 2'b00;
  localparam logic [1:0] NR_HDLC     = 2'b01;
  localparam logic [1:0] NR_FEAC     = 2'b10;
  localparam logic [1:0] NR_REGISTER = 2'b11;

  localparam logic [7:0] FA1_WORD      = 8'hf6;
  localparam logic [7:0] FA2_WORD      = 8'h28;
  localparam logic [7:0] ALL_ONES      = 8'hff;
  localparam logic [7:0] SINGLE_BIT    = 8'h01;
  localparam logic [7:0] REI_BIT_MASK  = 8'h40;
  localparam logic [2:0] FOUR_FRAMES_LEFT = 3'h3;
  localparam logic [2:0] NO_FRAMES_LEFT   = 3'h0;

  typedef enum logic [2:0] {
    OH_PAYLOAD, OH_FA1, OH_FA2, OH_EM, OH_TR, OH_MA, OH_NR, OH_GC
  } e3t_oh_type;

endpackage : e3t_pkg

// file: core/e3t_tx_overhead_ctrl.sv
/*
  E3 G.832 transmit overhead controller: APB register file, overhead byte
  sourcing, MA byte assembly, error insertion and AIS on a byte stream.
  Assumes an upstream formatter that marks each byte with its overhead
  position, and HDLC and FEAC sources that hold their next byte ready.
*/
// Behaviour
// [RULE1] GC byte from HDLC when select is 0, from the register when 1.
// [RULE2] NR source: 00 all ones, 01 HDLC, 10 FEAC, 11 register.
// [RULE3] HDLC feeding both NR and GC is one stream; each slot takes a byte.
// [RULE4] With REI automation defeated, manual REI bit goes to MA bit two.
// [RULE5] REI automatic from remote error input when defeat is 0.
// [RULE6] With RDI automation defeated, manual RDI bit goes to MA bit one.
// [RULE7] RDI automatic from receiver alarms when defeat is 0.
// [RULE8] Frame generation disabled passes FA1, FA2, EM and MA through; errors and AIS still overwrite.
// [RULE9] AIS bit forces the whole output stream to all ones.
// [RULE10] REI errors only while enabled; continuous bit repeats them every frame.
// [RULE11] Parity error inverts one EM bit, or all eight in block mode.
// [RULE12] Parity errors only while enabled; continuous bit repeats them every frame.
// [RULE13] Framing type: bit or word error, in one or four consecutive frames.
// [RULE14] Framing errors only while the framing enable is set.
// [RULE15] Each trigger rising edge inserts one error per enabled type; extra edges merge.
// [RULE16] Trigger taken from register bit or external input by source select.
// [RULE17] Payload type field goes to MA bits three to five.
// [RULE18] Last three MA bits derived from timing bits, or copied when disabled.
// [RULE19] One register holds GC value high byte and NR value low byte.
// [RULE20] Derived timing encoding: low three bits inverted when the top bit is set.
`timescale 1ns/100ps
module e3t_tx_overhead_ctrl
  import e3t_pkg::*;
(
  input  logic        REF_CLK,
  input  logic        RESET_N,
  input  logic        PSEL,
  input  logic        PENABLE,
  input  logic        PWRITE,
  input  logic [11:0] PADDR,
  input  logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic        PREADY,
  output logic        PSLVERR,
  input  logic [7:0]  IN_DATA,
  input  logic        IN_VALID,
  input  e3t_oh_type  IN_OH_POS,
  input  logic [7:0]  HDLC_BYTE,
  output logic        HDLC_TAKE,
  input  logic [7:0]  FEAC_BYTE,
  input  logic        RX_ALARM,
  input  logic        REMOTE_ERROR,
  input  logic        EXT_ERROR_INSERT,
  output logic [7:0]  OUT_DATA,
  output logic        OUT_VALID
);

  logic        rst_meta;
  logic        rst_n;
  logic [15:0] tcr;
  logic [15:0] teir;
  logic [15:0] tmabr;
  logic [15:0] tngbr;
  logic [15:0] next_tcr;
  logic [15:0] next_teir;
  logic [15:0] next_tmabr;
  logic [15:0] next_tngbr;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic [15:0] rd_word;
  logic        hit;
  logic        trig_q;
  logic        fe_pend;
  logic        pe_pend;
  logic        rei_pend;
  logic        fe_word;
  logic [2:0]  frames_left;
  logic        rei_seen;
  logic [7:0]  bip_acc;
  logic [7:0]  bip_prev;
  logic        next_trig_q;
  logic        next_fe_pend;
  logic        next_pe_pend;
  logic        next_rei_pend;
  logic        next_fe_word;
  logic [2:0]  next_frames_left;
  logic        next_rei_seen;
  logic [7:0]  next_bip_acc;
  logic [7:0]  next_bip_prev;
  logic [7:0]  next_out_data;
  logic        next_out_valid;
  logic        next_hdlc_take;
  logic        trig;
  logic        trig_rise;
  logic        fe_ins;
  logic        pe_ins;
  logic        rei_ins;
  logic        rdi_val;
  logic        rei_val;
  logic [2:0]  ts_val;
  logic [7:0]  ma_byte;
  logic [7:0]  nr_byte;
  logic [7:0]  gc_byte;
  logic [7:0]  byte_gen;
  logic [7:0]  byte_fin;

  wire fgd     = tcr[B_FRAME_GENERATION_DISABLE];
  wire ais     = tcr[B_FORCE_ALL_ONES_OUTPUT];
  wire gc_sel  = tcr[B_GC_SOURCE_SELECT];
  wire [1:0] nr_sel = tcr[B_NR_SOURCE_HI:B_NR_SOURCE_LO];
  wire fe_en   = teir[B_FRAMING_ERROR_ENABLE];
  wire pe_en   = teir[B_PARITY_ERROR_ENABLE];
  wire pe_cont = teir[B_PARITY_ERROR_CONTINUOUS];
  wire rei_en  = teir[B_REI_ERROR_ENABLE];
  wire rei_cont = teir[B_REI_ERROR_CONTINUOUS];
  wire at_fa1  = IN_VALID && (IN_OH_POS == OH_FA1);
  wire at_fa2  = IN_VALID && (IN_OH_POS == OH_FA2);
  wire at_em   = IN_VALID && (IN_OH_POS == OH_EM);
  wire at_ma   = IN_VALID && (IN_OH_POS == OH_MA);

  // Reset is released through two flops so no register sees a ragged edge
  always_ff @(posedge REF_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // Register bus: one wait state so that PREADY and PRDATA come from flops
  always_comb begin
    hit = 1'b1;
    rd_word = REG_RESET;
    case (PADDR)
      12'(IDX_TX_OVERHEAD_CONTROL  << ADDR_SHIFT): rd_word = tcr;
      12'(IDX_TX_ERROR_INSERTION   << ADDR_SHIFT): rd_word = teir;
      12'(IDX_TX_MA_BYTE_FIELDS    << ADDR_SHIFT): rd_word = tmabr;
      12'(IDX_TX_NR_GC_BYTE_VALUES << ADDR_SHIFT): rd_word = tngbr; // RULE19
      default: hit = 1'b0;
    endcase
    next_tcr = tcr;
    next_teir = teir;
    next_tmabr = tmabr;
    next_tngbr = tngbr;
    next_prdata = PRDATA;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    if (PSEL && PENABLE && !PREADY) begin
      next_pready = 1'b1;
      next_pslverr = !hit;
      next_prdata = {16'h0000, rd_word};
    end
    if (PSEL && PENABLE && PREADY && PWRITE && hit) begin
      case (PADDR)
        12'(IDX_TX_OVERHEAD_CONTROL  << ADDR_SHIFT): next_tcr = PWDATA[15:0] & MASK_TCR;
        12'(IDX_TX_ERROR_INSERTION   << ADDR_SHIFT): next_teir = PWDATA[15:0] & MASK_TEIR;
        12'(IDX_TX_MA_BYTE_FIELDS    << ADDR_SHIFT): next_tmabr = PWDATA[15:0] & MASK_TMABR;
        default: next_tngbr = PWDATA[15:0] & MASK_TNGBR;
      endcase
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      tcr     <= REG_RESET;
      teir    <= REG_RESET;
      tmabr   <= REG_RESET;
      tngbr   <= REG_RESET;
      PRDATA  <= 32'h00000000;
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
    end else begin
      tcr     <= next_tcr;
      teir    <= next_teir;
      tmabr   <= next_tmabr;
      tngbr   <= next_tngbr;
      PRDATA  <= next_prdata;
      PREADY  <= next_pready;
      PSLVERR <= next_pslverr;
    end
  end

  // Error triggers and pending flags; a new edge always wins over consumption
  always_comb begin
    trig = teir[B_ERROR_TRIGGER_SOURCE_SELECT] ? EXT_ERROR_INSERT
                                               : teir[B_SINGLE_ERROR_TRIGGER]; // RULE16
    trig_rise = trig && !trig_q; // RULE15
    next_trig_q = trig;
    fe_ins = at_fa1 && fe_en && (fe_pend || (frames_left != NO_FRAMES_LEFT)); // RULE14
    pe_ins = at_em && pe_en && (pe_cont || pe_pend); // RULE12
    rei_ins = at_ma && rei_en && (rei_cont || rei_pend); // RULE10
    // Edges between opportunities collapse into a single pending error
    next_fe_pend = (trig_rise && fe_en) || (fe_pend && fe_en && !(at_fa1 && fe_pend)); // RULE15
    next_pe_pend = (trig_rise && pe_en) || (pe_pend && pe_en && !pe_ins);
    next_rei_pend = (trig_rise && rei_en) || (rei_pend && rei_en && !rei_ins);
    next_frames_left = fe_en ? frames_left : NO_FRAMES_LEFT;
    next_fe_word = fe_word;
    if (fe_ins) begin
      next_fe_word = teir[B_FRAMING_TYPE_LO]; // RULE13
      if (fe_pend) begin
        next_frames_left = teir[B_FRAMING_TYPE_HI] ? FOUR_FRAMES_LEFT : NO_FRAMES_LEFT;
      end else begin
        next_frames_left = frames_left - 3'h1;
      end
    end else if (at_fa1) begin
      next_fe_word = 1'b0;
    end
  end

  // Overhead byte sources and MA assembly
  always_comb begin
    rdi_val = tcr[B_AUTO_RDI_DEFEAT] ? tcr[B_MANUAL_RDI_BIT] : RX_ALARM; // RULE6 RULE7
    rei_val = tcr[B_AUTO_REI_DEFEAT] ? tcr[B_MANUAL_REI_BIT]
                                     : (rei_seen || REMOTE_ERROR); // RULE4 RULE5
    next_rei_seen = REMOTE_ERROR || (rei_seen && !at_ma);
    if (tmabr[B_TIMING_SOURCE_GEN_DIS]) begin
      ts_val = tmabr[2:0]; // RULE18
    end else begin
      ts_val = tmabr[2:0] ^ {3{tmabr[B_TIMING_SOURCE_HI]}}; // RULE20
    end
    ma_byte = {rdi_val, rei_val, tmabr[B_PAYLOAD_TYPE_HI:B_PAYLOAD_TYPE_LO], ts_val}; // RULE17
    case (nr_sel) // RULE2
      NR_ALL_ONES: nr_byte = ALL_ONES;
      NR_HDLC:     nr_byte = HDLC_BYTE;
      NR_FEAC:     nr_byte = FEAC_BYTE;
      default:     nr_byte = tngbr[7:0];
    endcase
    gc_byte = gc_sel ? tngbr[15:8] : HDLC_BYTE; // RULE1
    next_hdlc_take = IN_VALID && (((IN_OH_POS == OH_NR) && (nr_sel == NR_HDLC)) ||
                                  ((IN_OH_POS == OH_GC) && !gc_sel)); // RULE3
    case (IN_OH_POS) // RULE8
      OH_FA1:  byte_gen = fgd ? IN_DATA : FA1_WORD;
      OH_FA2:  byte_gen = fgd ? IN_DATA : FA2_WORD;
      OH_EM:   byte_gen = fgd ? IN_DATA : bip_prev;
      OH_MA:   byte_gen = fgd ? IN_DATA : ma_byte;
      OH_NR:   byte_gen = nr_byte;
      OH_GC:   byte_gen = gc_byte;
      default: byte_gen = IN_DATA;
    endcase
    byte_fin = byte_gen;
    if (fe_ins) begin
      byte_fin = byte_gen ^ (teir[B_FRAMING_TYPE_LO] ? ALL_ONES : SINGLE_BIT); // RULE13
    end
    if (at_fa2 && fe_word) begin
      byte_fin = byte_gen ^ ALL_ONES;
    end
    if (pe_ins) begin
      byte_fin = byte_gen ^ (teir[B_PARITY_BLOCK_ERROR_MODE] ? ALL_ONES : SINGLE_BIT); // RULE11
    end
    if (rei_ins) begin
      byte_fin = byte_gen ^ REI_BIT_MASK; // RULE10
    end
    if (ais) begin
      byte_fin = ALL_ONES; // RULE9
    end
    next_out_data = IN_VALID ? byte_fin : OUT_DATA;
    next_out_valid = IN_VALID;
    // Parity runs over the sent frame; frames start at FA1
    next_bip_acc = bip_acc;
    next_bip_prev = bip_prev;
    if (at_fa1) begin
      next_bip_prev = bip_acc;
      next_bip_acc = byte_fin;
    end else if (IN_VALID) begin
      next_bip_acc = bip_acc ^ byte_fin;
    end
  end

  always_ff @(posedge REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      trig_q      <= 1'b0;
      fe_pend     <= 1'b0;
      pe_pend     <= 1'b0;
      rei_pend    <= 1'b0;
      fe_word     <= 1'b0;
      frames_left <= NO_FRAMES_LEFT;
      rei_seen    <= 1'b0;
      bip_acc     <= 8'h00;
      bip_prev    <= 8'h00;
      OUT_DATA    <= 8'h00;
      OUT_VALID   <= 1'b0;
      HDLC_TAKE   <= 1'b0;
    end else begin
      trig_q      <= next_trig_q;
      fe_pend     <= next_fe_pend;
      pe_pend     <= next_pe_pend;
      rei_pend    <= next_rei_pend;
      fe_word     <= next_fe_word;
      frames_left <= next_frames_left;
      rei_seen    <= next_rei_seen;
      bip_acc     <= next_bip_acc;
      bip_prev    <= next_bip_prev;
      OUT_DATA    <= next_out_data;
      OUT_VALID   <= next_out_valid;
      HDLC_TAKE   <= next_hdlc_take;
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!rst_n);

  property p_ais_ones;
    IN_VALID && ais |=> OUT_VALID && (OUT_DATA == ALL_ONES);
  endproperty
  a_ais_ones: assert property (p_ais_ones) else $error("AIS output not all ones"); // RULE9

  property p_gc_register;
    IN_VALID && (IN_OH_POS == OH_GC) && gc_sel && !ais |=> OUT_DATA == $past(tngbr[15:8]);
  endproperty
  a_gc_register: assert property (p_gc_register) else $error("GC byte not from register"); // RULE1

  property p_nr_ones;
    IN_VALID && (IN_OH_POS == OH_NR) && (nr_sel == NR_ALL_ONES) |=> OUT_DATA == ALL_ONES;
  endproperty
  a_nr_ones: assert property (p_nr_ones) else $error("NR byte not all ones"); // RULE2

  property p_hdlc_take;
    IN_VALID && (IN_OH_POS == OH_NR) && (nr_sel == NR_HDLC) |=> HDLC_TAKE ##1 !HDLC_TAKE || $past(IN_VALID);
  endproperty
  a_hdlc_take: assert property (p_hdlc_take) else $error("HDLC byte not taken for NR"); // RULE3

  property p_manual_rdi;
    at_ma && !fgd && !ais && tcr[B_AUTO_RDI_DEFEAT] |=> OUT_DATA[7] == $past(tcr[B_MANUAL_RDI_BIT]);
  endproperty
  a_manual_rdi: assert property (p_manual_rdi) else $error("MA RDI bit wrong"); // RULE6

  property p_payload_type;
    at_ma && !fgd && !ais |=> OUT_DATA[5:3] == $past(tmabr[B_PAYLOAD_TYPE_HI:B_PAYLOAD_TYPE_LO]);
  endproperty
  a_payload_type: assert property (p_payload_type) else $error("MA payload type wrong"); // RULE17

  property p_parity_block;
    at_em && !fgd && !ais && pe_en && pe_cont && teir[B_PARITY_BLOCK_ERROR_MODE]
      |=> OUT_DATA == ~$past(bip_prev);
  endproperty
  a_parity_block: assert property (p_parity_block) else $error("EM not fully inverted"); // RULE11

  property p_fgd_pass;
    at_fa1 && fgd && !fe_ins && !ais |=> OUT_DATA == $past(IN_DATA);
  endproperty
  a_fgd_pass: assert property (p_fgd_pass) else $error("FA1 not passed through"); // RULE8

  property p_framing_gated;
    !fe_en |-> !fe_ins ##1 (frames_left == NO_FRAMES_LEFT) && !fe_pend;
  endproperty
  a_framing_gated: assert property (p_framing_gated) else $error("Framing error while disabled"); // RULE14

  property p_edge_pends;
    trig_rise && pe_en ##1 pe_en |-> pe_pend;
  endproperty
  a_edge_pends: assert property (p_edge_pends) else $error("Trigger edge lost"); // RULE15

  property p_apb_ready;
    PSEL && PENABLE && !PREADY |=> PREADY ##1 !PREADY;
  endproperty
  a_apb_ready: assert property (p_apb_ready) else $error("APB ready timing wrong");

  c_ais: cover property (IN_VALID && ais);
  c_four_frames: cover property (fe_ins && (frames_left == FOUR_FRAMES_LEFT));
  c_hdlc_both: cover property (HDLC_TAKE && (nr_sel == NR_HDLC) && !gc_sel);
  c_rei_err: cover property (rei_ins && !rei_cont);

endmodule // e3t_tx_overhead_ctrl

// file: sim/e3t_line_sink.sv
/*
  Line-side sink for the E3 transmit byte stream: counts the bytes and keeps the last one.
  Assumes OUT_VALID marks each byte for exactly one clock.
*/
`timescale 1ns/100ps
module e3t_line_sink (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  data,
  input  wire logic        valid,
  output      logic [15:0] byte_count,
  output      logic [7:0]  last_byte
);
  // The line has no back-pressure, so every marked byte must be taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      byte_count <= 16'h0000;
      last_byte  <= 8'h00;
    end else if (valid) begin
      byte_count <= byte_count + 16'h0001;
      last_byte  <= data;
    end
  end
endmodule // e3t_line_sink

// file: sim/tb_top.sv
/*
  Bench for the E3 transmit overhead controller: APB tasks, a frame driver
  and a reference model of every output byte.
  Assumes parity of the frame before the first one is zero.
*/
`timescale 1ns/100ps
module tb_top;
  import e3t_pkg::*;
  logic        REF_CLK, RESET_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [7:0]  IN_DATA, HDLC_BYTE, FEAC_BYTE, OUT_DATA;
  logic        IN_VALID, HDLC_TAKE, RX_ALARM, REMOTE_ERROR, EXT_ERROR_INSERT, OUT_VALID;
  e3t_oh_type  IN_OH_POS;
  logic [15:0] line_count, tcr, teir, tma, tng;
  logic [7:0]  bip, hx;
  logic [2:0]  fr_left;
  logic        par_pend, rei_pend, rem, alm;
  int          err_total, checked, cyc, sent;
  logic [11:0] idxs [4] = '{IDX_TX_OVERHEAD_CONTROL, IDX_TX_ERROR_INSERTION,
                            IDX_TX_MA_BYTE_FIELDS, IDX_TX_NR_GC_BYTE_VALUES};
  logic [15:0] masks [4] = '{MASK_TCR, MASK_TEIR, MASK_TMABR, MASK_TNGBR};

  e3t_tx_overhead_ctrl e3t_tx_overhead_ctrl_i (.REF_CLK(REF_CLK), .RESET_N(RESET_N), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IN_DATA(IN_DATA), .IN_VALID(IN_VALID), .IN_OH_POS(IN_OH_POS), .HDLC_BYTE(HDLC_BYTE),
    .HDLC_TAKE(HDLC_TAKE), .FEAC_BYTE(FEAC_BYTE), .RX_ALARM(RX_ALARM), .REMOTE_ERROR(REMOTE_ERROR),
    .EXT_ERROR_INSERT(EXT_ERROR_INSERT), .OUT_DATA(OUT_DATA), .OUT_VALID(OUT_VALID));
  e3t_line_sink e3t_line_sink_i (.clk(REF_CLK), .rst_n(RESET_N), .data(OUT_DATA), .valid(OUT_VALID),
    .byte_count(line_count), .last_byte());

  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end

  // The HDLC source moves on only when a slot has consumed its byte
  always @(posedge REF_CLK) begin
    if (HDLC_TAKE === 1'b1) HDLC_BYTE <= HDLC_BYTE + 8'h01;
  end

  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    chk_reg({24'h0, got}, {24'h0, exp});
  endtask

  task automatic apb(input logic wr, input logic [11:0] idx, input logic [15:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge REF_CLK);
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= wr;
    PADDR   <= idx << ADDR_SHIFT;
    PWDATA  <= {16'h0, wd};
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    n = 0;
    do begin
      @(posedge REF_CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    rd = PRDATA;
    er = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    if (PREADY !== 1'b1) chk_reg(32'h0, 32'h1);
  endtask

  task automatic rreg(input logic [11:0] idx, input logic [15:0] exp, input logic experr);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, idx, 16'h0, rd, er);
    chk_reg(rd, {16'h0, exp});
    chk_reg({31'h0, er}, {31'h0, experr});
  endtask

  // Mirrors the registers and arms the errors that a trigger edge asks for
  task automatic wreg(input logic [11:0] idx, input logic [15:0] v);
    logic [31:0] rd;
    logic        er;
    if (idx == IDX_TX_ERROR_INSERTION && v[1] && !teir[1] && !v[0]) begin
      if (v[2]) fr_left = v[4] ? 3'h4 : 3'h1;
      par_pend = par_pend | v[5];
      rei_pend = rei_pend | v[8];
    end
    apb(1'b1, idx, v, rd, er);
    case (idx)
      IDX_TX_OVERHEAD_CONTROL: tcr = v;
      IDX_TX_ERROR_INSERTION:  teir = v;
      IDX_TX_MA_BYTE_FIELDS:   tma = v;
      default:                 tng = v;
    endcase
  endtask

  task automatic send(input e3t_oh_type p, input logic [7:0] d, input logic [7:0] e);
    @(posedge REF_CLK);
    IN_VALID  <= 1'b1;
    IN_DATA   <= d;
    IN_OH_POS <= p;
    if (p == OH_FA1) REMOTE_ERROR <= rem;
    if (p == OH_MA) REMOTE_ERROR <= 1'b0;
    @(posedge REF_CLK);
    IN_VALID <= 1'b0;
    #1;
    chk_byte(OUT_DATA, e);
  endtask

  task automatic frame(input logic [7:0] tr, input logic [7:0] pay);
    logic [7:0] e, d, prev;
    logic       fe, pe, re, fgd;
    e3t_oh_type p;
    fe = teir[2] && fr_left != 3'h0;
    pe = teir[5] && (teir[6] || par_pend);
    re = teir[8] && (teir[9] || rei_pend);
    if (fe) fr_left = fr_left - 3'h1;
    par_pend = 1'b0;
    rei_pend = 1'b0;
    fgd = tcr[1];
    prev = bip;
    bip = 8'h00;
    for (int i = 0; i < 9; i++) begin
      p = (i < 7) ? e3t_oh_type'(3'(i + 1)) : OH_PAYLOAD;
      d = (p == OH_TR) ? tr : pay + i[7:0];
      // Pass-through bytes still take errors on top
      case (p)
        OH_FA1:  e = (fgd ? d : FA1_WORD) ^ (fe ? (teir[3] ? ALL_ONES : SINGLE_BIT) : 8'h00);
        OH_FA2:  e = (fgd ? d : FA2_WORD) ^ ((fe && teir[3]) ? ALL_ONES : 8'h00);
        OH_EM:   e = (fgd ? d : prev) ^ (pe ? (teir[7] ? ALL_ONES : SINGLE_BIT) : 8'h00);
        OH_MA:   e = (fgd ? d : {tcr[2] ? tcr[3] : alm, tcr[4] ? tcr[5] : rem, tma[7:5],
                      tma[2:0] ^ (tma[4] ? 3'h0 : {3{tma[3]}})}) ^ (re ? REI_BIT_MASK : 8'h00);
        OH_NR: begin
          e = tcr[9] ? (tcr[8] ? tng[7:0] : FEAC_BYTE) : (tcr[8] ? hx : ALL_ONES);
          if (tcr[9:8] == NR_HDLC) hx = hx + 8'h01;
        end
        OH_GC: begin
          e = tcr[10] ? tng[15:8] : hx;
          if (!tcr[10]) hx = hx + 8'h01;
        end
        default: e = d;
      endcase
      if (tcr[0]) e = ALL_ONES;
      bip = bip ^ e;
      send(p, d, e);
      sent++;
    end
  endtask

  task automatic tend(input string name);
    $display("Test %s finished, mismatches so far %0d", name, err_total);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] rd;
    logic        er;
    {RESET_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, IN_DATA, IN_VALID} = '0;
    {RX_ALARM, REMOTE_ERROR, EXT_ERROR_INSERT, rem, alm, par_pend, rei_pend} = '0;
    {tcr, teir, tma, tng, bip, fr_left, err_total, checked, cyc, sent} = '0;
    IN_OH_POS = OH_PAYLOAD;
    HDLC_BYTE = 8'h30;
    hx = 8'h30;
    FEAC_BYTE = 8'hc3;
    repeat (6) @(posedge REF_CLK);
    RESET_N <= 1'b1;
    repeat (3) @(posedge REF_CLK);
    for (int k = 0; k < 4; k++) begin
      rreg(idxs[k], REG_RESET, 1'b0);
      wreg(idxs[k], 16'hffff);
      rreg(idxs[k], masks[k], 1'b0);
      wreg(idxs[k], 16'h0000);
    end
    apb(1'b1, 12'h120, 16'h1234, rd, er);
    chk_reg({31'h0, er}, 32'h1);
    rreg(12'h120, 16'h0000, 1'b1);
    tend("registers");
    wreg(IDX_TX_NR_GC_BYTE_VALUES, 16'ha55a);
    for (int k = 0; k < 8; k++) begin
      wreg(IDX_TX_OVERHEAD_CONTROL, {5'h0, k[2], k[1:0], 8'h00});
      frame(8'h11, 8'h40);
    end
    tend("sources");
    wreg(IDX_TX_MA_BYTE_FIELDS, 16'h00ad);
    wreg(IDX_TX_OVERHEAD_CONTROL, 16'h033c);
    frame(8'h22, 8'h50);
    wreg(IDX_TX_MA_BYTE_FIELDS, 16'h007e);
    wreg(IDX_TX_OVERHEAD_CONTROL, 16'h0314);
    frame(8'h23, 8'h51);
    wreg(IDX_TX_OVERHEAD_CONTROL, 16'h0300);
    alm = 1'b1;
    rem = 1'b1;
    RX_ALARM <= alm;
    frame(8'h24, 8'h52);
    alm = 1'b0;
    rem = 1'b0;
    RX_ALARM <= alm;
    frame(8'h25, 8'h53);
    tend("ma byte");
    for (int t = 0; t < 4; t++) begin
      wreg(IDX_TX_ERROR_INSERTION, 16'(t * 8 + 4));
      repeat (2) begin
        wreg(IDX_TX_ERROR_INSERTION, 16'(t * 8 + 6));
        wreg(IDX_TX_ERROR_INSERTION, 16'(t * 8 + 4));
      end
      repeat (5) frame(8'h33, 8'h60);
    end
    tend("framing errors");
    for (int b = 0; b < 2; b++) begin
      wreg(IDX_TX_ERROR_INSERTION, 16'h0120 | 16'(b * 128));
      wreg(IDX_TX_ERROR_INSERTION, 16'h0122 | 16'(b * 128));
      wreg(IDX_TX_ERROR_INSERTION, 16'h0120 | 16'(b * 128));
      repeat (2) frame(8'h34, 8'h61);
    end
    wreg(IDX_TX_ERROR_INSERTION, 16'h03e0);
    repeat (2) frame(8'h35, 8'h62);
    wreg(IDX_TX_ERROR_INSERTION, 16'h0021);
    wreg(IDX_TX_ERROR_INSERTION, 16'h0023);
    frame(8'h36, 8'h63);
    @(posedge REF_CLK);
    EXT_ERROR_INSERT <= 1'b1;
    par_pend = 1'b1;
    repeat (2) frame(8'h37, 8'h64);
    @(posedge REF_CLK);
    EXT_ERROR_INSERT <= 1'b0;
    wreg(IDX_TX_ERROR_INSERTION, 16'h0360);
    tend("parity and remote errors");
    wreg(IDX_TX_OVERHEAD_CONTROL, 16'h0302);
    frame(8'h44, 8'h70);
    wreg(IDX_TX_ERROR_INSERTION, 16'h0000);
    wreg(IDX_TX_OVERHEAD_CONTROL, 16'h0301);
    frame(8'h45, 8'h71);
    wreg(IDX_TX_OVERHEAD_CONTROL, 16'h0300);
    frame(8'h46, 8'h72);
    // The sink counts the last byte one edge after it is shown
    @(posedge REF_CLK);
    #1;
    chk_reg({16'h0, line_count}, 32'(sent));
    tend("pass-through and alarm");
    tally_and_finish();
  end
endmodule // tb_top
